// ### usb_host_control_channel.sv
/*
  Dedicated control-transfer channel of a USB host: settings registers on
  AXI4-Lite, a transfer sequencer that splits an IRP into transactions, and
  a completion interrupt.
  Assumes a transaction engine on clk_sys that takes txnReq and answers each
  request with one txnDone pulse.
*/
// Function
// - One control channel, reprogrammed per IRP for endpoints
// - Transactions run at the selected link speed
// - Toggle field loads start value, reads current
// - Issue SETUP, IN or OUT as selected
// - Tokens use the target function address
// - IRP goes to the target endpoint index
// - Split transactions use the hub address
// - Split transactions use the hub port
// - IRP byte count from high and low parts
// - FIFO region bounds, six regions, high/low parts
// - Setup stage sends the eight setup bytes
// - Channel splits IRP, interrupts on completion
`timescale 1ns/1ps
`default_nettype none

module usb_host_control_channel #(
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq,
  // Transaction request
  output logic txnReq,
  output logic [1:0] txnKind,
  output logic [1:0] txnSpeed,
  output logic txnToggle,
  output logic txnSplit,
  output logic [6:0] txnFuncAddr,
  output logic [3:0] txnEndpoint,
  output logic [6:0] txnHubAddr,
  output logic [6:0] txnHubPort,
  output logic [6:0] txnLength,
  output logic [63:0] txnSetupData,
  output logic [15:0] fifoRegionStart,
  output logic [15:0] fifoRegionEnd,
  // Transaction result
  input wire logic txnDone,
  input wire logic txnAck,
  input wire logic txnError,
  input wire logic [6:0] txnRxLength
);

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} state_e;

  // Settings
  logic [1:0] speedSel, next_speedSel;
  logic toggle, next_toggle;
  logic splitEn, next_splitEn;
  logic [1:0] kindSel, next_kindSel;
  logic [6:0] maxPkt, next_maxPkt;
  logic [6:0] funcAddr, next_funcAddr;
  logic [3:0] epIndex, next_epIndex;
  logic [6:0] hubAddr, next_hubAddr;
  logic [6:0] hubPort, next_hubPort;
  logic [7:0] countHi, next_countHi;
  logic [7:0] countLo, next_countLo;
  logic linkEn, next_linkEn;
  logic [2:0] linkRegion, next_linkRegion;
  logic [7:0] setupByte [usb_ctl_chan_pkg::SETUP_BYTES];
  logic [7:0] next_setupByte [usb_ctl_chan_pkg::SETUP_BYTES];
  logic [15:0] regionStart [usb_ctl_chan_pkg::NUM_REGIONS];
  logic [15:0] next_regionStart [usb_ctl_chan_pkg::NUM_REGIONS];
  logic [15:0] regionEnd [usb_ctl_chan_pkg::NUM_REGIONS];
  logic [15:0] next_regionEnd [usb_ctl_chan_pkg::NUM_REGIONS];

  // Bus state
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0] awAddr, next_awAddr;
  logic [15:0] wData, next_wData;
  logic [1:0] wStrb, next_wStrb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;

  // Sequencer state
  state_e state, next_state;
  logic [COUNT_W-1:0] remaining, next_remaining;
  logic next_txnReq, next_txnToggle;
  logic [6:0] next_txnLength;
  logic [15:0] next_regStart, next_regEnd;

  logic doWrite, writeHit, busy, startReq;
  logic [1:0] events;
  logic [1:0] intStatus, intMask;
  logic [6:0] pktLen, moved;
  logic [COUNT_W-1:0] afterMove;
  logic finished, regionOk;
  logic [2:0] regIdx, rdRegIdx;
  logic [31:0] readValue;
  logic readHit;

  assign doWrite = awHeld && wHeld && !bvalid;
  assign busy = (state != ST_IDLE);
  assign regIdx = 3'((awAddr - usb_ctl_chan_pkg::OFS_REGION_BASE) >> 4);
  assign rdRegIdx = 3'((s_axi_araddr - usb_ctl_chan_pkg::OFS_REGION_BASE) >> 4);
  assign regionOk = linkEn && (linkRegion < 3'(usb_ctl_chan_pkg::NUM_REGIONS));

  ctl_packet_sizer u_sizer (
    .remaining(16'(remaining)),
    .maxPacket(maxPkt),
    .kind(kindSel),
    .pktLen(pktLen)
  );

  ctl_irq_status #(.N(usb_ctl_chan_pkg::NUM_EVENTS)) u_irq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .events(events),
    .clearWrite(doWrite && awAddr == usb_ctl_chan_pkg::OFS_INT_STATUS && wStrb[0]),
    .maskWrite(doWrite && awAddr == usb_ctl_chan_pkg::OFS_INT_MASK && wStrb[0]),
    .writeData(wData[1:0]),
    .status(intStatus),
    .mask(intMask),
    .irq(irq)
  );

  // Bus handshakes; address and data may arrive in either order
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_awvalid && !awHeld) begin
      next_awHeld = 1'b1;
      next_awAddr = {s_axi_awaddr[7:2], 2'h0};
    end
    if (s_axi_wvalid && !wHeld) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata[15:0];
      next_wStrb = s_axi_wstrb[1:0];
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = writeHit ? usb_ctl_chan_pkg::RESP_OKAY : usb_ctl_chan_pkg::RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = readValue;
      next_rresp = readHit ? usb_ctl_chan_pkg::RESP_OKAY : usb_ctl_chan_pkg::RESP_SLVERR;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Read decode; unmapped addresses answer zero with SLVERR
  always_comb begin
    readValue = 32'h0000_0000;
    readHit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'h0})
      usb_ctl_chan_pkg::OFS_CONFIG_A: begin
        readValue[usb_ctl_chan_pkg::CFGA_SPEED_LSB +: 2] = speedSel;
        readValue[usb_ctl_chan_pkg::CFGA_TOGGLE_BIT] = toggle;
        readValue[usb_ctl_chan_pkg::CFGA_GO_BIT] = busy;
        readValue[usb_ctl_chan_pkg::CFGA_SPLIT_BIT] = splitEn;
      end
      usb_ctl_chan_pkg::OFS_CONFIG_B: readValue[1:0] = kindSel;
      usb_ctl_chan_pkg::OFS_MAX_PKT: readValue[6:0] = maxPkt;
      usb_ctl_chan_pkg::OFS_FUNC_ADDR: begin
        readValue[6:0] = funcAddr;
        readValue[usb_ctl_chan_pkg::FUNC_EP_LSB +: 4] = epIndex;
      end
      usb_ctl_chan_pkg::OFS_HUB_ADDR: begin
        readValue[6:0] = hubAddr;
        readValue[usb_ctl_chan_pkg::HUB_PORT_LSB +: 7] = hubPort;
      end
      usb_ctl_chan_pkg::OFS_COUNT_HI: readValue[7:0] = countHi;
      usb_ctl_chan_pkg::OFS_COUNT_LO: readValue[7:0] = countLo;
      usb_ctl_chan_pkg::OFS_REGION_LINK: begin
        readValue[0] = linkEn;
        readValue[usb_ctl_chan_pkg::LINK_REGION_LSB +: 3] = linkRegion;
      end
      usb_ctl_chan_pkg::OFS_INT_STATUS: readValue[1:0] = intStatus;
      usb_ctl_chan_pkg::OFS_INT_MASK: readValue[1:0] = intMask;
      usb_ctl_chan_pkg::OFS_CHAN_STATUS: begin
        readValue[0] = busy;
        readValue[usb_ctl_chan_pkg::STATUS_REMAIN_LSB +: 16] = 16'(remaining);
      end
      default: begin
        if (s_axi_araddr >= usb_ctl_chan_pkg::OFS_SETUP_BASE && s_axi_araddr <= usb_ctl_chan_pkg::OFS_SETUP_LAST) begin
          readValue[7:0] = setupByte[3'(s_axi_araddr[4:2])];
        end else if (s_axi_araddr >= usb_ctl_chan_pkg::OFS_REGION_BASE
            && s_axi_araddr <= usb_ctl_chan_pkg::OFS_REGION_LAST) begin
          unique case (s_axi_araddr[3:2])
            2'h0: readValue[7:0] = regionStart[rdRegIdx][15:8];
            2'h1: readValue[7:0] = regionStart[rdRegIdx][7:0];
            2'h2: readValue[7:0] = regionEnd[rdRegIdx][15:8];
            2'h3: readValue[7:0] = regionEnd[rdRegIdx][7:0];
          endcase
        end else begin
          readHit = 1'b0;
        end
      end
    endcase
  end

  // Register writes and the transfer sequencer
  always_comb begin
    next_speedSel = speedSel;
    next_toggle = toggle;
    next_splitEn = splitEn;
    next_kindSel = kindSel;
    next_maxPkt = maxPkt;
    next_funcAddr = funcAddr;
    next_epIndex = epIndex;
    next_hubAddr = hubAddr;
    next_hubPort = hubPort;
    next_countHi = countHi;
    next_countLo = countLo;
    next_linkEn = linkEn;
    next_linkRegion = linkRegion;
    next_setupByte = setupByte;
    next_regionStart = regionStart;
    next_regionEnd = regionEnd;
    next_state = state;
    next_remaining = remaining;
    next_txnReq = txnReq;
    next_txnToggle = txnToggle;
    next_txnLength = txnLength;
    next_regStart = fifoRegionStart;
    next_regEnd = fifoRegionEnd;
    writeHit = 1'b1;
    startReq = 1'b0;
    events = 2'h0;
    moved = (kindSel == usb_ctl_chan_pkg::KIND_IN) ? txnRxLength : txnLength;
    afterMove = (remaining > COUNT_W'(moved)) ? remaining - COUNT_W'(moved) : '0;
    finished = (kindSel == usb_ctl_chan_pkg::KIND_SETUP) || (moved < maxPkt)
        || (kindSel == usb_ctl_chan_pkg::KIND_IN && afterMove == '0);
    if (doWrite && wStrb[0]) begin
      unique case (awAddr)
        usb_ctl_chan_pkg::OFS_CONFIG_A: begin
          next_speedSel = wData[usb_ctl_chan_pkg::CFGA_SPEED_LSB +: 2];
          next_splitEn = wData[usb_ctl_chan_pkg::CFGA_SPLIT_BIT];
          // Toggle loads only between transfers to keep the sequence intact
          if (!busy) next_toggle = wData[usb_ctl_chan_pkg::CFGA_TOGGLE_BIT];
          startReq = wData[usb_ctl_chan_pkg::CFGA_GO_BIT];
        end
        usb_ctl_chan_pkg::OFS_CONFIG_B: next_kindSel = wData[1:0];
        usb_ctl_chan_pkg::OFS_MAX_PKT: next_maxPkt = wData[6:0];
        usb_ctl_chan_pkg::OFS_FUNC_ADDR: next_funcAddr = wData[6:0];
        usb_ctl_chan_pkg::OFS_HUB_ADDR: next_hubAddr = wData[6:0];
        usb_ctl_chan_pkg::OFS_COUNT_HI: next_countHi = wData[7:0];
        usb_ctl_chan_pkg::OFS_COUNT_LO: next_countLo = wData[7:0];
        usb_ctl_chan_pkg::OFS_REGION_LINK: begin
          next_linkEn = wData[0];
          next_linkRegion = wData[usb_ctl_chan_pkg::LINK_REGION_LSB +: 3];
        end
        usb_ctl_chan_pkg::OFS_INT_STATUS, usb_ctl_chan_pkg::OFS_INT_MASK: writeHit = 1'b1;
        usb_ctl_chan_pkg::OFS_CHAN_STATUS: writeHit = 1'b1;
        default: begin
          if (awAddr >= usb_ctl_chan_pkg::OFS_SETUP_BASE && awAddr <= usb_ctl_chan_pkg::OFS_SETUP_LAST) begin
            next_setupByte[3'(awAddr[4:2])] = wData[7:0];
          end else if (awAddr >= usb_ctl_chan_pkg::OFS_REGION_BASE
              && awAddr <= usb_ctl_chan_pkg::OFS_REGION_LAST) begin
            unique case (awAddr[3:2])
              2'h0: next_regionStart[regIdx][15:8] = wData[7:0];
              2'h1: next_regionStart[regIdx][7:0] = wData[7:0];
              2'h2: next_regionEnd[regIdx][15:8] = wData[7:0];
              2'h3: next_regionEnd[regIdx][7:0] = wData[7:0];
            endcase
          end else begin
            writeHit = 1'b0;
          end
        end
      endcase
    end
    if (doWrite && wStrb[1]) begin
      if (awAddr == usb_ctl_chan_pkg::OFS_FUNC_ADDR) next_epIndex = wData[usb_ctl_chan_pkg::FUNC_EP_LSB +: 4];
      if (awAddr == usb_ctl_chan_pkg::OFS_HUB_ADDR) next_hubPort = wData[usb_ctl_chan_pkg::HUB_PORT_LSB +: 7];
    end
    unique case (state)
      ST_IDLE: begin
        if (startReq && regionOk) begin
          // Settings are reused per IRP, so one channel serves many endpoints
          next_remaining = COUNT_W'({countHi, countLo});
          next_regStart = regionStart[linkRegion];
          next_regEnd = regionEnd[linkRegion];
          next_state = ST_ISSUE;
        end else if (startReq) begin
          events[usb_ctl_chan_pkg::INT_ERROR_BIT] = 1'b1;
        end
      end
      ST_ISSUE: begin
        next_txnLength = pktLen;
        next_txnToggle = (kindSel == usb_ctl_chan_pkg::KIND_SETUP) ? 1'b0 : toggle;
        next_txnReq = 1'b1;
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (txnDone) begin
          next_txnReq = 1'b0;
          if (txnError) begin
            events[usb_ctl_chan_pkg::INT_ERROR_BIT] = 1'b1;
            next_state = ST_IDLE;
          end else if (!txnAck) begin
            // No handshake: retry the same packet, toggle unchanged
            next_state = ST_ISSUE;
          end else begin
            next_toggle = (kindSel == usb_ctl_chan_pkg::KIND_SETUP) ? 1'b1 : !toggle;
            next_remaining = (kindSel == usb_ctl_chan_pkg::KIND_SETUP) ? '0 : afterMove;
            if (finished) begin
              events[usb_ctl_chan_pkg::INT_DONE_BIT] = 1'b1;
              next_state = ST_IDLE;
            end else begin
              next_state = ST_ISSUE;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld <= 1'b0;
      wData <= 16'h0000;
      wStrb <= 2'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
      speedSel <= 2'h0;
      toggle <= 1'b0;
      splitEn <= 1'b0;
      kindSel <= 2'h0;
      maxPkt <= usb_ctl_chan_pkg::MAX_PKT_RESET;
      funcAddr <= 7'h00;
      epIndex <= 4'h0;
      hubAddr <= 7'h00;
      hubPort <= 7'h00;
      countHi <= 8'h00;
      countLo <= 8'h00;
      linkEn <= 1'b0;
      linkRegion <= 3'h0;
      setupByte <= '{default: 8'h00};
      regionStart <= '{default: 16'h0000};
      regionEnd <= '{default: 16'h0000};
      state <= ST_IDLE;
      remaining <= '0;
      txnReq <= 1'b0;
      txnToggle <= 1'b0;
      txnLength <= 7'h00;
      fifoRegionStart <= 16'h0000;
      fifoRegionEnd <= 16'h0000;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      speedSel <= next_speedSel;
      toggle <= next_toggle;
      splitEn <= next_splitEn;
      kindSel <= next_kindSel;
      maxPkt <= next_maxPkt;
      funcAddr <= next_funcAddr;
      epIndex <= next_epIndex;
      hubAddr <= next_hubAddr;
      hubPort <= next_hubPort;
      countHi <= next_countHi;
      countLo <= next_countLo;
      linkEn <= next_linkEn;
      linkRegion <= next_linkRegion;
      setupByte <= next_setupByte;
      regionStart <= next_regionStart;
      regionEnd <= next_regionEnd;
      state <= next_state;
      remaining <= next_remaining;
      txnReq <= next_txnReq;
      txnToggle <= next_txnToggle;
      txnLength <= next_txnLength;
      fifoRegionStart <= next_regStart;
      fifoRegionEnd <= next_regEnd;
    end
  end

  // Transaction fields mirror settings registers directly
  assign txnKind = kindSel;
  assign txnSpeed = speedSel;
  assign txnSplit = splitEn;
  assign txnFuncAddr = funcAddr;
  assign txnEndpoint = epIndex;
  assign txnHubAddr = hubAddr;
  assign txnHubPort = hubPort;
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  genvar g;
  generate
    for (g = 0; g < usb_ctl_chan_pkg::SETUP_BYTES; g++) begin : g_setup
      assign txnSetupData[g*8 +: 8] = setupByte[g];
    end
  endgenerate

endmodule

`default_nettype wire

// ### usb_ctl_chan_pkg.sv
/*
  Shared constants for the host control-transfer channel: register offsets,
  field positions, reset values and encodings.
  Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
*/
`default_nettype none

package usb_ctl_chan_pkg;

  localparam int ADDR_W = 8;
  localparam int NUM_REGIONS = 6;
  localparam int SETUP_BYTES = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG_A = 8'h00;
  localparam logic [7:0] OFS_CONFIG_B = 8'h04;
  localparam logic [7:0] OFS_MAX_PKT = 8'h08;
  localparam logic [7:0] OFS_FUNC_ADDR = 8'h0C;
  localparam logic [7:0] OFS_HUB_ADDR = 8'h10;
  localparam logic [7:0] OFS_COUNT_HI = 8'h14;
  localparam logic [7:0] OFS_COUNT_LO = 8'h18;
  localparam logic [7:0] OFS_REGION_LINK = 8'h1C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h20;
  localparam logic [7:0] OFS_INT_MASK = 8'h24;
  localparam logic [7:0] OFS_CHAN_STATUS = 8'h28;
  localparam logic [7:0] OFS_SETUP_BASE = 8'h40;
  localparam logic [7:0] OFS_SETUP_LAST = 8'h5C;
  localparam logic [7:0] OFS_REGION_BASE = 8'h80;
  localparam logic [7:0] OFS_REGION_LAST = 8'hDC;

  // Field positions
  localparam int CFGA_SPEED_LSB = 0;
  localparam int CFGA_TOGGLE_BIT = 2;
  localparam int CFGA_GO_BIT = 3;
  localparam int CFGA_SPLIT_BIT = 4;
  localparam int FUNC_EP_LSB = 8;
  localparam int HUB_PORT_LSB = 8;
  localparam int LINK_REGION_LSB = 4;
  localparam int STATUS_REMAIN_LSB = 16;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ERROR_BIT = 1;
  localparam int NUM_EVENTS = 2;

  // Reset values and fixed sizes
  localparam logic [6:0] MAX_PKT_RESET = 7'h08;
  localparam logic [6:0] SETUP_LEN = 7'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {KIND_SETUP, KIND_IN, KIND_OUT} kind_e;
  typedef enum logic [1:0] {SPEED_HIGH, SPEED_FULL, SPEED_LOW} speed_e;

endpackage

`default_nettype wire

// ### ctl_packet_sizer.sv
/*
  Picks the length of the next packet of a control transfer.
  Assumes the remaining count and max packet size are stable registers.
*/
`timescale 1ns/1ps
`default_nettype none

module ctl_packet_sizer (
  // Transfer state
  input wire logic [15:0] remaining,
  input wire logic [6:0] maxPacket,
  input wire logic [1:0] kind,
  // Result
  output logic [6:0] pktLen
);

  always_comb begin
    if (kind == usb_ctl_chan_pkg::KIND_SETUP) begin
      pktLen = usb_ctl_chan_pkg::SETUP_LEN;
    end else if (remaining < {9'h000, maxPacket}) begin
      pktLen = remaining[6:0];
    end else begin
      pktLen = maxPacket;
    end
  end

endmodule

`default_nettype wire

// ### ctl_irq_status.sv
/*
  Sticky event status, write-one-to-clear, with a mask and one level irq.
  Assumes events are single-cycle pulses from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ctl_irq_status #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Events and software access
  input wire logic [N-1:0] events,
  input wire logic clearWrite,
  input wire logic maskWrite,
  input wire logic [N-1:0] writeData,
  // State
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  logic [N-1:0] next_status;
  logic [N-1:0] next_mask;
  logic next_irq;

  always_comb begin
    // Set wins so an event in the clearing cycle survives
    next_status = (status & ~(clearWrite ? writeData : '0)) | events;
    next_mask = maskWrite ? writeData : mask;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

endmodule

`default_nettype wire

// ### usb_ctl_chan_chk_sva.sv
/*
  Port checker for the control channel, attached by the bind at the foot.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_ctl_chan_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Transaction link
  input wire logic txnReq,
  input wire logic txnDone,
  input wire logic [1:0] txnKind,
  input wire logic txnToggle,
  input wire logic [6:0] txnLength
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_request_hold: assert property (txnReq && !txnDone |=> txnReq && $stable(txnLength) && $stable(txnKind))
    else $error("request changed before done");
  a_request_release: assert property (txnReq && txnDone |=> !txnReq)
    else $error("request held after done");
  a_setup_data0: assert property (txnReq && txnKind == 2'd0 |-> !txnToggle && txnLength == 7'd8)
    else $error("setup packet not eight bytes of DATA0");
  a_packet_bound: assert property (txnReq |-> txnLength <= 7'd64)
    else $error("packet above largest size");
  cover property (txnReq && txnDone);
  cover property (txnReq && txnKind == 2'd2 && txnLength == 7'd0);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind usb_host_control_channel usb_ctl_chan_chk chk (.*);
`default_nettype wire

// ### usb_txn_engine_model.sv
/*
  Stand-in for the transaction engine and the bus beyond it.
  Assumes a request stands until the edge after its done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_txn_engine_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Request
  input wire logic txnReq,
  input wire logic [6:0] txnLength,
  // Answer
  output logic txnDone,
  output logic txnAck,
  output logic txnError,
  output logic [6:0] txnRxLength
);
  int waitLeft;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txnDone <= 0;
      txnAck <= 0;
      txnError <= 0;
      txnRxLength <= 0;
      waitLeft <= 0;
    end else if (txnDone || !txnReq) begin
      // Junk outside the pulse, so stale results are not trusted
      txnDone <= 0;
      txnAck <= ~txnAck;
      txnRxLength <= ~txnRxLength;
      waitLeft <= $urandom % 4;
    end else if (waitLeft > 0) begin
      waitLeft <= waitLeft - 1;
    end else begin
      txnDone <= 1;
      // Random NAK so the retry path is exercised
      txnAck <= ($urandom % 4) != 0;
      txnRxLength <= txnLength;
    end
  end
endmodule
`default_nettype wire

// ### usb_host_control_channel_tb_top.sv
/*
  Bench: AXI4-Lite master, packet model in queues, result checks.
  Assumes the engine model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_host_control_channel_tb_top;
  logic clk_sys = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1;
  logic txnSplit;
  logic [3:0] txnEndpoint, ep;
  logic [6:0] txnHubAddr, txnHubPort;
  logic [15:0] fifoRegionStart, fifoRegionEnd;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic txnReq, txnToggle, txnDone, txnAck, txnError;
  logic [1:0] s_axi_bresp, s_axi_rresp, txnKind, txnSpeed, spd, kd;
  logic [6:0] txnFuncAddr, txnLength, txnRxLength, fa;
  logic [63:0] txnSetupData, expSetup;
  int num_errors = 0, n_checks = 0, expLen[$], expTog[$], i;
  int kt[5] = '{0, 2, 2, 1, 1};
  int ct[5] = '{0, 16, 20, 16, 5};
  always #2.5 clk_sys = ~clk_sys;
  usb_host_control_channel dut (.*);
  usb_txn_engine_model eng (.*);
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo;
    num_errors++;
    $display("FAIL %0t: wait ran out", $time);
    print_verdict;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (n == 100) tmo;
    check(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (n == 100) tmo;
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
  endtask
  // Packet split model: short or zero-length packet closes the data stage
  task automatic run(input int k, input int cnt, input logic t);
    int rem, len, n;
    logic tg;
    kd = 2'(k);
    spd = 2'($urandom % 3);
    fa = 7'($urandom);
    ep = 4'($urandom);
    wr(8'h0C, {20'h0, ep, 1'b0, fa}, 0);
    wr(8'h04, 32'(k), 0);
    wr(8'h14, 32'(cnt >> 8), 0);
    wr(8'h18, 32'(cnt & 255), 0);
    rem = cnt;
    tg = t;
    if (k == 0) begin
      expLen.push_back(8);
      expTog.push_back(0);
      tg = 1;
    end else do begin
      len = rem < 8 ? rem : 8;
      expLen.push_back(len);
      expTog.push_back(tg);
      rem -= len;
      tg = ~tg;
    end while (len == 8 && (k == 2 || rem > 0));
    wr(8'h00, {27'h0, 1'(k == 1), 1'b1, t, spd}, 0);
    for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk_sys);
    if (n == 2000) tmo;
    check(expLen.size(), 0);
    rd(8'h20, 1, 0);
    wr(8'h20, 1, 0);
    rd(8'h00, {27'h0, 1'(k == 1), 1'b0, tg, spd}, 0);
    $display("transfer kind %0d count %0d done", k, cnt);
  endtask
  always @(posedge clk_sys) begin
    if (rst_n && txnReq && txnDone) begin
      // A NAK retries the same packet, so only an ack consumes it
      check(txnLength, expLen[0]);
      check(txnToggle, expTog[0]);
      if (txnAck) begin
        expLen.delete(0);
        expTog.delete(0);
      end
      check(txnEndpoint, ep);
      check(txnHubAddr, 7'h15);
      check(txnHubPort, 7'h2A);
      check(txnSplit, kd == 1);
      check(fifoRegionStart, 16'h0010);
      check(fifoRegionEnd, 16'h004F);
      check(txnSpeed, spd);
      check(txnFuncAddr, fa);
      check(txnKind, kd);
      if (kd == 0) check(txnSetupData, expSetup);
    end
  end
  initial begin
    void'($urandom(95441));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rd(8'h08, 8, 0);
    rd(8'h30, 0, 2);
    wr(8'h30, 5, 2);
    for (i = 0; i < 8; i++) begin
      expSetup[8*i+:8] = 8'($urandom);
      wr(8'(64 + 4 * i), 32'(expSetup[8*i+:8]), 0);
    end
    wr(8'h24, 1, 0);
    wr(8'h10, 32'h0000_2A15, 0);
    wr(8'h84, 32'h0000_0010, 0);
    // Region of 64 bytes, above the 8-byte max packet
    wr(8'h8C, 32'h0000_004F, 0);
    wr(8'h1C, 1, 0);
    for (i = 0; i < 5; i++) run(kt[i], ct[i], 1'($urandom));
    // Unlinked region: go is refused, error flagged
    wr(8'h1C, 0, 0);
    wr(8'h00, 8, 0);
    repeat (4) @(posedge clk_sys);
    check(irq, 0);
    rd(8'h20, 2, 0);
    wr(8'h24, 3, 0);
    repeat (3) @(posedge clk_sys);
    check(irq, 1);
    wr(8'h20, 2, 0);
    repeat (3) @(posedge clk_sys);
    check(irq, 0);
    $display("error and interrupt test done");
    print_verdict;
  end
endmodule
`default_nettype wire
